// ---- src/tacs_pkg.sv ----
package tacs_pkg;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_INV_LEAD = 8'h06;
    localparam logic [7:0] CMD_INIT_ARG = 8'h00;
    localparam logic [7:0] CMD_POLL_ARG = 8'h04;
    localparam logic [3:0] CMD_SLOT_CODE = 4'h6;
    localparam logic [3:0] SLOT_RESERVED = 4'h0;
    localparam logic [7:0] CMD_SELECT = 8'h0E;
    localparam logic [7:0] CMD_COMPLETE = 8'h0F;

    // ****************************************
    // Frame and check constants
    // ****************************************
    localparam logic [2:0] REQ_LEN_ONE = 3'h3;
    localparam logic [2:0] REQ_LEN_TWO = 3'h4;
    localparam logic [2:0] REQ_LEN_MAX = 3'h7;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic [7:0] ID_RESET = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_READY = 3'b000,
        ST_INVENTORY = 3'b001,
        ST_SELECTED = 3'b010,
        ST_DESELECTED = 3'b011,
        ST_DEACTIVATED = 3'b100
    } tacs_state_e;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_ID = 3'b001,
        TX_CL = 3'b010,
        TX_CH = 3'b011,
        TX_END = 3'b100
    } tacs_tx_e;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] param;
        logic two_byte;
    } tacs_req_s;

    // Reflected CRC over one byte, low bit first
    function automatic logic [15:0] tacs_crc_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : tacs_crc_byte

endpackage : tacs_pkg

// ---- src/tacs_session_fsm.sv ----
`timescale 1ns/1ps
`default_nettype none

module tacs_session_fsm (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic LINK_CLK,
    input wire logic RX_SOF,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_EOF,
    output var logic TX_SOF,
    output var logic TX_VALID,
    output var logic [7:0] TX_DATA,
    output var logic TX_EOF,
    output var tacs_pkg::tacs_state_e TAG_STATE,
    output logic [7:0] TAG_ID
);
    import tacs_pkg::*;

    // ****************************************
    // Link reset
    // ****************************************
    logic rst_link_meta;
    logic rst_link;

    always_ff @(posedge LINK_CLK) begin
        rst_link_meta <= RST;
        rst_link <= rst_link_meta;
    end

    // ****************************************
    // Request receiver (link domain)
    // ****************************************
    logic [4:0][7:0] byte_sr, next_byte_sr;
    logic [2:0] byte_cnt, next_byte_cnt;
    logic [15:0] crc_q, next_crc_q;
    logic [15:0] crc_p1, next_crc_p1;
    logic [15:0] crc_p2, next_crc_p2;
    logic in_frame, next_in_frame;
    tacs_req_s req, next_req;
    logic req_tgl, next_req_tgl;
    logic crc_ok;
    logic len_ok;

    assign crc_ok = ({byte_sr[0], byte_sr[1]} == ~crc_p2);
    assign len_ok = (byte_cnt == REQ_LEN_ONE) || (byte_cnt == REQ_LEN_TWO);

    always_comb begin
        next_byte_sr = byte_sr;
        next_byte_cnt = byte_cnt;
        next_crc_q = crc_q;
        next_crc_p1 = crc_p1;
        next_crc_p2 = crc_p2;
        next_in_frame = in_frame;
        next_req = req;
        next_req_tgl = req_tgl;
        if (RX_SOF) begin
            next_byte_cnt = 3'h0;
            next_crc_q = CRC_INIT;
            next_in_frame = 1'b1;
        end else if (RX_VALID && in_frame) begin
            next_byte_sr = {byte_sr[3:0], RX_DATA};
            if (byte_cnt != REQ_LEN_MAX) begin
                next_byte_cnt = byte_cnt + 3'h1;
            end
            next_crc_p2 = crc_p1;
            next_crc_p1 = crc_q;
            next_crc_q = tacs_crc_byte(crc_q, RX_DATA);
        end else if (RX_EOF && in_frame) begin
            next_in_frame = 1'b0;
            if (len_ok && crc_ok) begin
                next_req.two_byte = (byte_cnt == REQ_LEN_TWO);
                next_req.code = (byte_cnt == REQ_LEN_TWO) ? byte_sr[3] : byte_sr[2];
                next_req.param = byte_sr[2];
                next_req_tgl = ~req_tgl;
            end
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (rst_link) begin
            byte_sr <= '0;
            byte_cnt <= 3'h0;
            crc_q <= CRC_INIT;
            crc_p1 <= CRC_INIT;
            crc_p2 <= CRC_INIT;
            in_frame <= 1'b0;
            req <= '0;
            req_tgl <= 1'b0;
        end else begin
            byte_sr <= next_byte_sr;
            byte_cnt <= next_byte_cnt;
            crc_q <= next_crc_q;
            crc_p1 <= next_crc_p1;
            crc_p2 <= next_crc_p2;
            in_frame <= next_in_frame;
            req <= next_req;
            req_tgl <= next_req_tgl;
        end
    end

    // ****************************************
    // Session state machine (system domain)
    // ****************************************
    logic req_meta, req_s, req_s_d;
    logic req_evt;
    tacs_state_e state, next_state;
    logic [7:0] tag_id, next_tag_id;
    logic slot_valid, next_slot_valid;
    logic [15:0] lfsr, next_lfsr;
    logic [7:0] ans_id, next_ans_id;
    logic ans_tgl, next_ans_tgl;
    logic is_init, is_poll, is_query, is_select, is_complete, id_match;

    assign req_evt = req_s ^ req_s_d;
    assign is_init = req.two_byte && (req.code == CMD_INV_LEAD) && (req.param == CMD_INIT_ARG);
    assign is_poll = req.two_byte && (req.code == CMD_INV_LEAD) && (req.param == CMD_POLL_ARG);
    assign is_query = !req.two_byte && (req.code[3:0] == CMD_SLOT_CODE)
        && (req.code[7:4] != SLOT_RESERVED);
    assign is_select = req.two_byte && (req.code == CMD_SELECT);
    assign is_complete = !req.two_byte && (req.code == CMD_COMPLETE);
    assign id_match = (req.param == tag_id);

    always_comb begin
        next_state = state;
        next_tag_id = tag_id;
        next_slot_valid = slot_valid;
        next_ans_id = ans_id;
        next_ans_tgl = ans_tgl;
        next_lfsr = {lfsr[14:0], ^(lfsr & LFSR_TAPS)};
        if (req_evt) begin
            case (state)
                ST_READY: begin
                    if (is_init) begin
                        next_state = ST_INVENTORY;
                        next_tag_id = lfsr[7:0];
                        next_slot_valid = 1'b0;
                        next_ans_id = lfsr[7:0];
                        next_ans_tgl = ~ans_tgl;
                    end
                end
                ST_INVENTORY: begin
                    if (is_poll) begin
                        next_tag_id = {tag_id[7:4], lfsr[3:0]};
                        next_slot_valid = 1'b1;
                        if (lfsr[3:0] == SLOT_RESERVED) begin
                            next_ans_id = {tag_id[7:4], lfsr[3:0]};
                            next_ans_tgl = ~ans_tgl;
                        end
                    end else if (is_query) begin
                        if (slot_valid && (tag_id[3:0] == req.code[7:4])) begin
                            next_ans_id = tag_id;
                            next_ans_tgl = ~ans_tgl;
                        end
                    end else if (is_select && id_match) begin
                        next_state = ST_SELECTED;
                        next_ans_id = tag_id;
                        next_ans_tgl = ~ans_tgl;
                    end
                end
                ST_SELECTED: begin
                    if (is_select && id_match) begin
                        next_ans_id = tag_id;
                        next_ans_tgl = ~ans_tgl;
                    end else if (is_select) begin
                        next_state = ST_DESELECTED;
                    end else if (is_complete) begin
                        next_state = ST_DEACTIVATED;
                    end
                end
                ST_DESELECTED: begin
                    if (is_select && id_match) begin
                        next_state = ST_SELECTED;
                        next_ans_id = tag_id;
                        next_ans_tgl = ~ans_tgl;
                    end
                end
                ST_DEACTIVATED: begin
                    next_state = ST_DEACTIVATED;
                end
                default: begin
                    next_state = ST_READY;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        req_meta <= req_tgl;
        req_s <= req_meta;
        if (RST) begin
            req_s_d <= 1'b0;
            state <= ST_READY;
            tag_id <= ID_RESET;
            slot_valid <= 1'b0;
            lfsr <= LFSR_SEED;
            ans_id <= ID_RESET;
            ans_tgl <= 1'b0;
        end else begin
            req_s_d <= req_s;
            state <= next_state;
            tag_id <= next_tag_id;
            slot_valid <= next_slot_valid;
            lfsr <= next_lfsr;
            ans_id <= next_ans_id;
            ans_tgl <= next_ans_tgl;
        end
    end

    assign TAG_STATE = state;
    assign TAG_ID = tag_id;

    // ****************************************
    // Answer transmitter (link domain)
    // ****************************************
    logic ans_meta, ans_s, ans_s_d;
    logic ans_evt;
    tacs_tx_e tx_st, next_tx_st;
    logic [7:0] tx_id, next_tx_id;
    logic [15:0] tx_crc, next_tx_crc;
    logic next_tx_sof, next_tx_valid, next_tx_eof;
    logic [7:0] next_tx_data;

    assign ans_evt = ans_s ^ ans_s_d;

    always_comb begin
        next_tx_st = tx_st;
        next_tx_id = tx_id;
        next_tx_crc = tx_crc;
        next_tx_sof = 1'b0;
        next_tx_valid = 1'b0;
        next_tx_eof = 1'b0;
        next_tx_data = 8'h00;
        case (tx_st)
            TX_IDLE: begin
                if (ans_evt) begin
                    next_tx_sof = 1'b1;
                    next_tx_id = ans_id;
                    next_tx_st = TX_ID;
                end
            end
            TX_ID: begin
                next_tx_valid = 1'b1;
                next_tx_data = tx_id;
                next_tx_crc = ~tacs_crc_byte(CRC_INIT, tx_id);
                next_tx_st = TX_CL;
            end
            TX_CL: begin
                next_tx_valid = 1'b1;
                next_tx_data = tx_crc[7:0];
                next_tx_st = TX_CH;
            end
            TX_CH: begin
                next_tx_valid = 1'b1;
                next_tx_data = tx_crc[15:8];
                next_tx_st = TX_END;
            end
            TX_END: begin
                next_tx_eof = 1'b1;
                next_tx_st = TX_IDLE;
            end
            default: begin
                next_tx_st = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge LINK_CLK) begin
        ans_meta <= ans_tgl;
        ans_s <= ans_meta;
        if (rst_link) begin
            ans_s_d <= 1'b0;
            tx_st <= TX_IDLE;
            tx_id <= ID_RESET;
            tx_crc <= CRC_INIT;
            TX_SOF <= 1'b0;
            TX_VALID <= 1'b0;
            TX_DATA <= 8'h00;
            TX_EOF <= 1'b0;
        end else begin
            ans_s_d <= ans_s;
            tx_st <= next_tx_st;
            tx_id <= next_tx_id;
            tx_crc <= next_tx_crc;
            TX_SOF <= next_tx_sof;
            TX_VALID <= next_tx_valid;
            TX_DATA <= next_tx_data;
            TX_EOF <= next_tx_eof;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_init_enter_inv: assert property (req_evt && is_init && state == ST_READY |=>
        state == ST_INVENTORY && ans_tgl != $past(ans_tgl) && ans_id == tag_id)
        else $error("initiate did not enter inventory with answer");
    a_poll_ignored: assert property (req_evt && is_poll && state != ST_INVENTORY |=>
        $stable(tag_id) && $stable(ans_tgl))
        else $error("slot poll acted outside inventory");
    a_poll_draw: assert property (req_evt && is_poll && state == ST_INVENTORY |=>
        tag_id[3:0] == $past(lfsr[3:0]) && slot_valid)
        else $error("slot poll did not draw slot");
    a_slot_hold: assert property (!(req_evt && (is_poll || is_init)) |=>
        $stable(tag_id[3:0]))
        else $error("slot changed without poll or initiate");
    a_poll_answer: assert property (req_evt && is_poll && state == ST_INVENTORY |=>
        (ans_tgl != $past(ans_tgl)) == (tag_id[3:0] == SLOT_RESERVED))
        else $error("poll answer does not follow zero slot");
    a_query_match: assert property (req_evt && is_query && state == ST_INVENTORY |=>
        (ans_tgl != $past(ans_tgl)) == ($past(slot_valid) && tag_id[3:0] == $past(req.code[7:4])))
        else $error("slot query answer wrong");
    a_query_ignored: assert property (req_evt && is_query && state != ST_INVENTORY |=>
        $stable(ans_tgl) && $stable(state))
        else $error("slot query acted outside inventory");
    a_reject_other: assert property (req_evt && !(is_init || is_poll || is_query || is_select)
        && state != ST_SELECTED |=> $stable(state) && $stable(ans_tgl))
        else $error("unselected tag accepted foreign command");
    a_select_enter: assert property (req_evt && is_select && id_match
        && (state == ST_INVENTORY || state == ST_DESELECTED || state == ST_SELECTED)
        |=> state == ST_SELECTED && ans_tgl != $past(ans_tgl) && ans_id == $past(req.param))
        else $error("matching select not taken");
    a_deselect: assert property (req_evt && is_select && !id_match && state == ST_SELECTED |=>
        state == ST_DESELECTED && $stable(ans_tgl))
        else $error("mismatching select did not deselect");
    a_complete_lock: assert property (req_evt && is_complete && state == ST_SELECTED |=>
        state == ST_DEACTIVATED ##1 state == ST_DEACTIVATED [*3])
        else $error("completion did not lock tag");
    a_complete_silent: assert property (req_evt && is_complete |=> $stable(ans_tgl))
        else $error("completion produced an answer");
    a_complete_ignored: assert property (req_evt && is_complete && state != ST_SELECTED
        && state != ST_DEACTIVATED |=> $stable(state))
        else $error("completion acted outside selected");
    a_bad_check_drop: assert property (@(posedge LINK_CLK) disable iff (rst_link)
        RX_EOF && !RX_SOF && !RX_VALID && in_frame && !crc_ok |=> $stable(req_tgl))
        else $error("frame with bad check bytes accepted");
    a_answer_frame: assert property (@(posedge LINK_CLK) disable iff (rst_link)
        TX_SOF |=> TX_VALID && TX_DATA == tx_id ##1 TX_VALID ##1 TX_VALID ##1 TX_EOF && !TX_VALID)
        else $error("answer frame out of order");

    c_init_seen: cover property (req_evt && is_init && state == ST_READY);
    c_poll_answer: cover property (req_evt && is_poll && state == ST_INVENTORY
        && lfsr[3:0] == SLOT_RESERVED);
    c_select_seen: cover property (req_evt && is_select && id_match && state == ST_INVENTORY);
    c_complete_seen: cover property (req_evt && is_complete && state == ST_SELECTED);

endmodule : tacs_session_fsm

`default_nettype wire

// ---- verification/tacs_reader_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module tacs_reader_model (
    input wire logic link_clk,
    output var logic rx_sof,
    output var logic rx_valid,
    output var logic [7:0] rx_data,
    output var logic rx_eof,
    input wire logic tx_sof,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_eof
);

    logic [7:0] ans[$];
    int sof_seen;
    int eof_seen;
    logic [7:0] last;

    // Reflected check over one byte, own implementation
    function automatic logic [15:0] chk_add(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ 16'h8408) : (r >> 1);
        end
        return r;
    endfunction : chk_add

    initial begin
        rx_sof = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_eof = 1'b0;
        last = 8'h00;
    end

    task automatic put(input logic [7:0] d);
        @(posedge link_clk);
        rx_sof <= 1'b0;
        rx_valid <= 1'b1;
        rx_data <= d;
        last = d;
    endtask : put

    // Frame is code, optional parameter, then check low and check high
    task automatic send_frame(input logic [7:0] b0, input logic [7:0] b1, input logic two,
                              input logic corrupt);
        logic [15:0] c;
        c = chk_add(16'hFFFF, b0);
        if (two) begin
            c = chk_add(c, b1);
        end
        c = ~c ^ {15'h0000, corrupt};
        ans.delete();
        sof_seen = 0;
        eof_seen = 0;
        @(posedge link_clk);
        rx_sof <= 1'b1;
        put(b0);
        if (two) begin
            put(b1);
        end
        put(c[7:0]);
        put(c[15:8]);
        @(posedge link_clk);
        rx_valid <= 1'b0;
        rx_data <= ~last;
        rx_eof <= 1'b1;
        @(posedge link_clk);
        rx_eof <= 1'b0;
    endtask : send_frame

    always @(posedge link_clk) begin
        if (tx_sof) begin
            sof_seen++;
        end
        if (tx_valid) begin
            ans.push_back(tx_data);
        end
        if (tx_eof) begin
            eof_seen++;
        end
    end

endmodule : tacs_reader_model

`default_nettype wire

// ---- verification/tag_anticollision_session_fsm_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tag_anticollision_session_fsm_tb;
    import tacs_pkg::*;

    logic SYS_CLK = 1'b0;
    logic LINK_CLK = 1'b0;
    logic RST = 1'b1;
    logic RX_SOF, RX_VALID, RX_EOF, TX_SOF, TX_VALID, TX_EOF;
    logic [7:0] RX_DATA, TX_DATA, TAG_ID;
    tacs_state_e TAG_STATE;
    int fail_count = 0;
    int check_count = 0;

    always #50 SYS_CLK = ~SYS_CLK;

    initial begin
        #1.7;
        forever #3 LINK_CLK = ~LINK_CLK;
    end

    tacs_session_fsm dut (.SYS_CLK(SYS_CLK), .RST(RST), .LINK_CLK(LINK_CLK), .RX_SOF(RX_SOF),
        .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_EOF(RX_EOF), .TX_SOF(TX_SOF),
        .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_EOF(TX_EOF), .TAG_STATE(TAG_STATE),
        .TAG_ID(TAG_ID));

    tacs_reader_model rdr (.link_clk(LINK_CLK), .rx_sof(RX_SOF), .rx_valid(RX_VALID),
        .rx_data(RX_DATA), .rx_eof(RX_EOF), .tx_sof(TX_SOF), .tx_valid(TX_VALID),
        .tx_data(TX_DATA), .tx_eof(TX_EOF));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Room for the answer and the spacing between requests
    task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, input logic two,
                        input logic corrupt);
        rdr.send_frame(b0, b1, two, corrupt);
        repeat (10) @(posedge SYS_CLK);
        #1;
    endtask : xfer

    task automatic expect_answer(input logic yes, input string what);
        logic [15:0] c;
        c = ~rdr.chk_add(16'hFFFF, TAG_ID);
        if (!yes) begin
            check(8'(rdr.ans.size() + rdr.sof_seen), 8'h00, what);
        end else if (rdr.ans.size() != 3) begin
            check(8'(rdr.ans.size()), 8'h03, what);
        end else begin
            check(rdr.ans[0], TAG_ID, what);
            check(rdr.ans[1], c[7:0], what);
            check(rdr.ans[2], c[15:8], what);
            check(8'(rdr.sof_seen + rdr.eof_seen), 8'h02, what);
        end
    endtask : expect_answer

    task automatic state_is(input tacs_state_e s, input string what);
        check({5'h00, TAG_STATE}, {5'h00, s}, what);
    endtask : state_is

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        state_is(ST_READY, "reset state");
        check(TAG_ID, 8'h00, "reset id");
        check({5'h00, TX_SOF, TX_VALID, TX_EOF}, 8'h00, "reset tx");
        $display("test reset done");
    endtask : t_reset

    task automatic t_ready_refusals();
        xfer(CMD_INV_LEAD, CMD_POLL_ARG, 1'b1, 1'b0);
        expect_answer(1'b0, "poll in ready");
        xfer(8'h16, 8'h00, 1'b0, 1'b0);
        expect_answer(1'b0, "query in ready");
        xfer(CMD_COMPLETE, 8'h00, 1'b0, 1'b0);
        state_is(ST_READY, "completion in ready");
        xfer(CMD_SELECT, 8'h00, 1'b1, 1'b0);
        state_is(ST_READY, "select in ready");
        xfer(CMD_INV_LEAD, CMD_INIT_ARG, 1'b1, 1'b1);
        state_is(ST_READY, "bad check initiate");
        expect_answer(1'b0, "bad check answer");
        $display("test ready_refusals done");
    endtask : t_ready_refusals

    task automatic t_initiate();
        xfer(CMD_INV_LEAD, CMD_INIT_ARG, 1'b1, 1'b0);
        state_is(ST_INVENTORY, "initiate state");
        expect_answer(1'b1, "initiate answer");
        xfer(8'h06, 8'h00, 1'b0, 1'b0);
        expect_answer(1'b0, "query index zero");
        $display("test initiate done");
    endtask : t_initiate

    task automatic t_poll();
        logic [7:0] id;
        logic [3:0] other;
        for (int k = 0; k < 6; k++) begin
            id = TAG_ID;
            xfer(CMD_INV_LEAD, CMD_POLL_ARG, 1'b1, 1'b0);
            check({4'h0, TAG_ID[7:4]}, {4'h0, id[7:4]}, "poll keeps high nibble");
            expect_answer(TAG_ID[3:0] == 4'h0, "poll answer");
            if (TAG_ID[3:0] != 4'h0) begin
                id = TAG_ID;
                other = (id[3:0] == 4'hF) ? 4'h1 : id[3:0] + 4'h1;
                xfer({other, CMD_SLOT_CODE}, 8'h00, 1'b0, 1'b0);
                expect_answer(1'b0, "query other slot");
                xfer({id[3:0], CMD_SLOT_CODE}, 8'h00, 1'b0, 1'b0);
                expect_answer(1'b1, "query own slot");
                check(TAG_ID, id, "slot held");
            end
        end
        $display("test poll done");
    endtask : t_poll

    task automatic t_select();
        logic [7:0] id;
        id = TAG_ID;
        xfer(CMD_COMPLETE, 8'h00, 1'b0, 1'b0);
        state_is(ST_INVENTORY, "completion in inventory");
        xfer(CMD_SELECT, id, 1'b1, 1'b0);
        state_is(ST_SELECTED, "select match");
        expect_answer(1'b1, "select answer");
        xfer(CMD_SELECT, id ^ 8'h80, 1'b1, 1'b0);
        state_is(ST_DESELECTED, "select other id");
        xfer(CMD_SELECT, id, 1'b1, 1'b0);
        state_is(ST_SELECTED, "reselect");
        xfer(CMD_COMPLETE, 8'h00, 1'b0, 1'b0);
        state_is(ST_DEACTIVATED, "completion");
        expect_answer(1'b0, "completion silent");
        xfer(CMD_INV_LEAD, CMD_INIT_ARG, 1'b1, 1'b0);
        state_is(ST_DEACTIVATED, "locked after completion");
        expect_answer(1'b0, "locked silent");
        $display("test select done");
    endtask : t_select

    initial begin
        #500us;
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge SYS_CLK);
        RST <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        #1;
        t_reset();
        t_ready_refusals();
        t_initiate();
        t_poll();
        t_select();
        print_verdict();
    end

endmodule : tag_anticollision_session_fsm_tb

`default_nettype wire
